// ===== design/csmcg_pkg.sv
package csmcg_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_CLOCK_DIVIDER = 4'h0;
  localparam logic [3:0] ADDR_GATE_1 = 4'h1;
  localparam logic [3:0] ADDR_GATE_2 = 4'h2;
  localparam logic [3:0] ADDR_GATE_3 = 4'h3;
  localparam logic [3:0] ADDR_GATE_4 = 4'h4;
  localparam logic [3:0] ADDR_POWER_STATUS = 4'h5;

  // Clock divider register fields.
  localparam int RETURN_ON_INTERRUPT_BIT = 15;
  localparam int RATIO_MSB = 14;
  localparam int RATIO_LSB = 12;
  localparam int SLOW_EN_BIT = 11;
  localparam logic [15:0] CLOCK_DIVIDER_MASK = 16'hF800;
  localparam logic [15:0] CLOCK_DIVIDER_RESET = 16'h0000;

  // Implemented bits of the four gating registers.
  localparam logic [15:0] GATE_1_MASK = 16'h0EF9;
  localparam logic [15:0] GATE_2_MASK = 16'h001F;
  localparam logic [15:0] GATE_3_MASK = 16'h00AA;
  localparam logic [15:0] GATE_4_MASK = 16'h0008;
  localparam logic [15:0] GATE_RESET = 16'h0000;

  // Gating bit positions.
  localparam int TIMER_ONE_OFF = 11;
  localparam int QUAD_DECODER_ONE_OFF = 10;
  localparam int PWM_UNIT_OFF = 9;
  localparam int I2C_ONE_OFF = 7;
  localparam int UART_TWO_OFF = 6;
  localparam int UART_ONE_OFF = 5;
  localparam int SPI_TWO_OFF = 4;
  localparam int SPI_ONE_OFF = 3;
  localparam int ADC_UNIT_OFF = 0;
  localparam int CAPCOMP_ONE_OFF = 0;
  localparam int CRC_ENGINE_OFF = 7;
  localparam int QUAD_DECODER_TWO_OFF = 5;
  localparam int UART_THREE_OFF = 3;
  localparam int I2C_TWO_OFF = 1;
  localparam int REF_CLOCK_OUT_OFF = 3;

  localparam int NUM_MODULES = 19;

  // Wake delay after Idle or Sleep, in system clock cycles.
  localparam int WAKE_CYCLES = 3;

  typedef enum logic [1:0] {
    PS_RUN = 2'b00,
    PS_ENTER = 2'b01,
    PS_SAVE = 2'b10,
    PS_WAKE = 2'b11
  } csmcg_ps_state_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } csmcg_bus_type;

endpackage : csmcg_pkg

// ===== design/csmcg_gate_cell.sv
`timescale 1ns/1ps
// One module enable: delayed one instruction cycle after its gating bit moves.
module csmcg_gate_cell (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic instr_tick_in,
  input wire logic gate_off_in,
  input wire logic present_in,
  output logic module_en_out
);

  logic en_r;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      en_r <= 1'b1;
    end else if (instr_tick_in) begin
      en_r <= ~gate_off_in;
    end
  end

  assign module_en_out = en_r & present_in;

endmodule : csmcg_gate_cell

// ===== design/csmcg_top.sv
`timescale 1ns/1ps
module csmcg_top #(
  parameter logic [csmcg_pkg::NUM_MODULES-1:0] PRESENT = '1
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic power_save_instruction_in,
  input wire logic power_save_idle_in,
  input wire logic irq_pending_in,
  output logic irq_deliver_out,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic sleeping_out,
  output logic idle_out,
  output logic [csmcg_pkg::NUM_MODULES-1:0] module_clk_en_out,
  output logic [csmcg_pkg::NUM_MODULES-1:0] module_reg_wr_ok_out,
  output logic [csmcg_pkg::NUM_MODULES-1:0] module_rd_valid_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register port.

  csmcg_pkg::csmcg_bus_type bus;
  assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  // Software-visible registers and the registered read data.
  logic [15:0] clock_divider_reg_r;
  logic [15:0] module_gate_reg_1_r;
  logic [15:0] module_gate_reg_2_r;
  logic [15:0] module_gate_reg_3_r;
  logic [15:0] module_gate_reg_4_r;
  logic [15:0] rdata_r;

  // Write strobes per register; unmapped addresses match none of them.
  wire wr_clock_divider = bus.wr && (bus.addr == csmcg_pkg::ADDR_CLOCK_DIVIDER);
  wire wr_gate1 = bus.wr && (bus.addr == csmcg_pkg::ADDR_GATE_1);
  wire wr_gate2 = bus.wr && (bus.addr == csmcg_pkg::ADDR_GATE_2);
  wire wr_gate3 = bus.wr && (bus.addr == csmcg_pkg::ADDR_GATE_3);
  wire wr_gate4 = bus.wr && (bus.addr == csmcg_pkg::ADDR_GATE_4);

  wire slow_en = clock_divider_reg_r[csmcg_pkg::SLOW_EN_BIT];
  wire return_on_interrupt = clock_divider_reg_r[csmcg_pkg::RETURN_ON_INTERRUPT_BIT];
  wire [2:0] ratio_sel = clock_divider_reg_r[csmcg_pkg::RATIO_MSB:csmcg_pkg::RATIO_LSB];

  // Return-on-interrupt fires on a pending interrupt while slowed.
  wire ret_int_fire = return_on_interrupt && slow_en && irq_pending_in;
  wire [15:0] clock_divider_wr_value = bus.wdata & csmcg_pkg::CLOCK_DIVIDER_MASK;

  logic [15:0] clock_divider_reg_nxt;
  always_comb begin
    clock_divider_reg_nxt = clock_divider_reg_r;
    if (wr_clock_divider) begin
      clock_divider_reg_nxt = clock_divider_wr_value;
    end
    if (ret_int_fire) begin
      // Hardware clear wins over a coincident software write of the same bit.
      clock_divider_reg_nxt[csmcg_pkg::SLOW_EN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clock_divider_reg_r <= csmcg_pkg::CLOCK_DIVIDER_RESET;
    end else begin
      clock_divider_reg_r <= clock_divider_reg_nxt;
    end
  end

  // Each gating register keeps only its implemented bits, so unused positions read zero.
  wire [15:0] module_gate_reg_1_nxt = wr_gate1 ? (bus.wdata & csmcg_pkg::GATE_1_MASK)
    : module_gate_reg_1_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      module_gate_reg_1_r <= csmcg_pkg::GATE_RESET;
    end else begin
      module_gate_reg_1_r <= module_gate_reg_1_nxt;
    end
  end

  wire [15:0] module_gate_reg_2_nxt = wr_gate2 ? (bus.wdata & csmcg_pkg::GATE_2_MASK)
    : module_gate_reg_2_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      module_gate_reg_2_r <= csmcg_pkg::GATE_RESET;
    end else begin
      module_gate_reg_2_r <= module_gate_reg_2_nxt;
    end
  end

  wire [15:0] module_gate_reg_3_nxt = wr_gate3 ? (bus.wdata & csmcg_pkg::GATE_3_MASK)
    : module_gate_reg_3_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      module_gate_reg_3_r <= csmcg_pkg::GATE_RESET;
    end else begin
      module_gate_reg_3_r <= module_gate_reg_3_nxt;
    end
  end

  wire [15:0] module_gate_reg_4_nxt = wr_gate4 ? (bus.wdata & csmcg_pkg::GATE_4_MASK)
    : module_gate_reg_4_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      module_gate_reg_4_r <= csmcg_pkg::GATE_RESET;
    end else begin
      module_gate_reg_4_r <= module_gate_reg_4_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-save sequencing.

  csmcg_pkg::csmcg_ps_state_type ps_r;
  csmcg_pkg::csmcg_ps_state_type ps_nxt;
  logic idle_mode_r;
  logic [1:0] wake_cnt_r;

  always_comb begin
    ps_nxt = ps_r;
    unique case (ps_r)
      csmcg_pkg::PS_RUN: begin
        if (power_save_instruction_in) ps_nxt = csmcg_pkg::PS_ENTER;
      end
      csmcg_pkg::PS_ENTER: begin
        // Entry always completes before any interrupt is looked at.
        ps_nxt = csmcg_pkg::PS_SAVE;
      end
      csmcg_pkg::PS_SAVE: begin
        if (irq_pending_in) ps_nxt = csmcg_pkg::PS_WAKE;
      end
      csmcg_pkg::PS_WAKE: begin
        if (wake_cnt_r == 2'd0) ps_nxt = csmcg_pkg::PS_RUN;
      end
    endcase
  end

  // Idle or Sleep is latched with the instruction, so a later change of the select pin is harmless.
  wire st_run = ps_r == csmcg_pkg::PS_RUN;
  wire ps_start = st_run && power_save_instruction_in;
  wire idle_mode_nxt = ps_start ? power_save_idle_in : idle_mode_r;
  // The wake counter loads once on entry to WAKE and counts down to zero.
  wire wake_load = (ps_nxt == csmcg_pkg::PS_WAKE) && (ps_r != csmcg_pkg::PS_WAKE);
  wire [1:0] wake_cnt_nxt = wake_load ? 2'(csmcg_pkg::WAKE_CYCLES - 1)
    : ((wake_cnt_r != 2'd0) ? wake_cnt_r - 2'd1 : wake_cnt_r);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ps_r <= csmcg_pkg::PS_RUN;
    end else begin
      ps_r <= ps_nxt;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      idle_mode_r <= 1'b0;
    end else begin
      idle_mode_r <= idle_mode_nxt;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_cnt_r <= 2'd0;
    end else begin
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  // State decodes shared by the outputs below.
  wire st_enter = ps_r == csmcg_pkg::PS_ENTER;
  wire st_save = ps_r == csmcg_pkg::PS_SAVE;
  wire st_wake = ps_r == csmcg_pkg::PS_WAKE;
  wire in_save = st_enter || st_save;
  wire cpu_halted = in_save || st_wake;
  wire sleeping = in_save && !idle_mode_r;

  assign sleeping_out = sleeping;
  assign idle_out = in_save && idle_mode_r;
  // Interrupts reach the CPU only once it runs again.
  assign irq_deliver_out = irq_pending_in && !cpu_halted;
  assign periph_clk_en_out = !sleeping;

  ////////////////////////////////////////////////////////////////////////////
  // Slow-core divider and instruction tick.

  // Counter on the system clock, held only in Sleep, so CPU enables fall on peripheral edges.
  logic [6:0] div_cnt_r;
  // The counter holds in Sleep, where no clock would reach the CPU anyway.
  wire [6:0] div_cnt_nxt = sleeping ? div_cnt_r : div_cnt_r + 7'd1;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt_r <= 7'd0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  // Ratio code n lets the CPU through on one system cycle in two to the power n.
  wire [6:0] ratio_mask = 7'((8'd1 << ratio_sel) - 8'd1);
  wire slow_tick = (div_cnt_r & ratio_mask) == 7'd0;
  wire cpu_tick = slow_en ? slow_tick : 1'b1;
  assign cpu_clk_en_out = cpu_tick && !cpu_halted;

  ////////////////////////////////////////////////////////////////////////////
  // Module gating.

  // First register: timer, decoder, PWM, serial units and converter.
  wire timer_one_off = module_gate_reg_1_r[csmcg_pkg::TIMER_ONE_OFF];
  wire quad_decoder_one_off = module_gate_reg_1_r[csmcg_pkg::QUAD_DECODER_ONE_OFF];
  wire pwm_unit_off = module_gate_reg_1_r[csmcg_pkg::PWM_UNIT_OFF];
  wire i2c_one_off = module_gate_reg_1_r[csmcg_pkg::I2C_ONE_OFF];
  wire uart_two_off = module_gate_reg_1_r[csmcg_pkg::UART_TWO_OFF];
  wire uart_one_off = module_gate_reg_1_r[csmcg_pkg::UART_ONE_OFF];
  wire spi_two_off = module_gate_reg_1_r[csmcg_pkg::SPI_TWO_OFF];
  wire spi_one_off = module_gate_reg_1_r[csmcg_pkg::SPI_ONE_OFF];
  wire adc_unit_off = module_gate_reg_1_r[csmcg_pkg::ADC_UNIT_OFF];

  // Second register: capture/compare units one to five.
  wire capcomp_one_off = module_gate_reg_2_r[csmcg_pkg::CAPCOMP_ONE_OFF];
  wire capcomp_two_off = module_gate_reg_2_r[csmcg_pkg::CAPCOMP_ONE_OFF + 1];
  wire capcomp_three_off = module_gate_reg_2_r[csmcg_pkg::CAPCOMP_ONE_OFF + 2];
  wire capcomp_four_off = module_gate_reg_2_r[csmcg_pkg::CAPCOMP_ONE_OFF + 3];
  wire capcomp_five_off = module_gate_reg_2_r[csmcg_pkg::CAPCOMP_ONE_OFF + 4];

  // Third and fourth registers.
  wire crc_engine_off = module_gate_reg_3_r[csmcg_pkg::CRC_ENGINE_OFF];
  wire quad_decoder_two_off = module_gate_reg_3_r[csmcg_pkg::QUAD_DECODER_TWO_OFF];
  wire uart_three_off = module_gate_reg_3_r[csmcg_pkg::UART_THREE_OFF];
  wire i2c_two_off = module_gate_reg_3_r[csmcg_pkg::I2C_TWO_OFF];
  wire ref_clock_out_off = module_gate_reg_4_r[csmcg_pkg::REF_CLOCK_OUT_OFF];

  wire [csmcg_pkg::NUM_MODULES-1:0] gate_bits = {
    ref_clock_out_off,
    i2c_two_off,
    uart_three_off,
    quad_decoder_two_off,
    crc_engine_off,
    capcomp_five_off,
    capcomp_four_off,
    capcomp_three_off,
    capcomp_two_off,
    capcomp_one_off,
    adc_unit_off,
    spi_one_off,
    spi_two_off,
    uart_one_off,
    uart_two_off,
    i2c_one_off,
    pwm_unit_off,
    quad_decoder_one_off,
    timer_one_off
  };

  // The instruction cycle is the CPU tick before halt gating, so the delay follows slow-core mode.
  wire [csmcg_pkg::NUM_MODULES-1:0] mod_en;
  genvar gi;
  generate
    for (gi = 0; gi < csmcg_pkg::NUM_MODULES; gi++) begin : g_cell
      csmcg_gate_cell u_cell (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .instr_tick_in(cpu_tick),
        .gate_off_in(gate_bits[gi]),
        .present_in(PRESENT[gi]),
        .module_en_out(mod_en[gi])
      );
    end
  endgenerate

  // Sleep removes every module clock, while register access follows the gate alone.
  wire [csmcg_pkg::NUM_MODULES-1:0] awake_mask = {csmcg_pkg::NUM_MODULES{!sleeping}};
  assign module_clk_en_out = mod_en & awake_mask;
  assign module_reg_wr_ok_out = mod_en;
  assign module_rd_valid_out = mod_en;

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  // Status fields for software; the word is read-only.
  wire [3:0] status_bits = {cpu_halted, idle_out, sleeping, ret_int_fire};
  wire [15:0] status_word = {12'h000, status_bits};

  // Unmapped addresses select nothing, so they read as zero.
  wire rd_hit_clock_divider = bus.addr == csmcg_pkg::ADDR_CLOCK_DIVIDER;
  wire rd_hit_gate1 = bus.addr == csmcg_pkg::ADDR_GATE_1;
  wire rd_hit_gate2 = bus.addr == csmcg_pkg::ADDR_GATE_2;
  wire rd_hit_gate3 = bus.addr == csmcg_pkg::ADDR_GATE_3;
  wire rd_hit_gate4 = bus.addr == csmcg_pkg::ADDR_GATE_4;
  wire rd_hit_status = bus.addr == csmcg_pkg::ADDR_POWER_STATUS;

  wire [15:0] rd_sel = ({16{rd_hit_clock_divider}} & clock_divider_reg_r)
    | ({16{rd_hit_gate1}} & module_gate_reg_1_r)
    | ({16{rd_hit_gate2}} & module_gate_reg_2_r)
    | ({16{rd_hit_gate3}} & module_gate_reg_3_r)
    | ({16{rd_hit_gate4}} & module_gate_reg_4_r)
    | ({16{rd_hit_status}} & status_word);

  // Read data stand in the cycle after each read strobe and are zero otherwise.
  wire [15:0] rdata_nxt = bus.rd ? rd_sel : 16'h0000;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

endmodule : csmcg_top

// ===== testbench/csmcg_core_monitor.sv
`timescale 1ns/1ps
module csmcg_core_monitor #(
  parameter logic [csmcg_pkg::NUM_MODULES-1:0] PRESENT = '1
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic power_save_instruction_in,
  input wire logic power_save_idle_in,
  input wire logic irq_pending_in,
  input wire logic irq_deliver_out,
  input wire logic cpu_clk_en_out,
  input wire logic periph_clk_en_out,
  input wire logic sleeping_out,
  input wire logic idle_out,
  input wire logic [csmcg_pkg::NUM_MODULES-1:0] module_clk_en_out,
  input wire logic [csmcg_pkg::NUM_MODULES-1:0] module_reg_wr_ok_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  // Shadow of the last written slow enable; return-on-interrupt may clear the real bit, which only weakens the check.
  logic slow_seen_r;
  wire halt = sleeping_out | idle_out;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) slow_seen_r <= 1'b0;
    else if (reg_wr_in && reg_addr_in == csmcg_pkg::ADDR_CLOCK_DIVIDER) slow_seen_r <= reg_wdata_in[11];
  end
  ////////////////////////////////////////
  rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000) else $error("read data not zero");
  periph_run_a: assert property (periph_clk_en_out != sleeping_out) else $error("peripheral clock wrong");
  halt_cpu_a: assert property (halt |-> !cpu_clk_en_out) else $error("cpu clocked while halted");
  irq_hold_a: assert property (halt |-> !irq_deliver_out) else $error("interrupt not held off");
  ps_enter_a: assert property ((!halt)[*4] ##0 power_save_instruction_in |=>
    idle_out == $past(power_save_idle_in) && sleeping_out != idle_out) else $error("wrong power save mode");
  wake_time_a: assert property (halt ##0 irq_pending_in[*6] |-> irq_deliver_out) else $error("wake too slow");
  full_rate_a: assert property (!slow_seen_r && irq_deliver_out |-> cpu_clk_en_out) else $error("cpu not full rate");
  wr_ok_a: assert property (!sleeping_out |-> module_reg_wr_ok_out == module_clk_en_out) else $error("write gate");
  absent_mod_a: assert property ((module_clk_en_out & ~PRESENT) == '0) else $error("absent module on");
  gate_delay_a: assert property (reg_wr_in && reg_addr_in == csmcg_pkg::ADDR_GATE_1 && reg_wdata_in[11]
    && !slow_seen_r && !halt |-> ##[1:2] !module_clk_en_out[0]) else $error("gate delay wrong");
  cover property (idle_out);
  cover property (sleeping_out);
  cover property (reg_rd_in ##1 reg_rdata_out != 16'h0000);
endmodule : csmcg_core_monitor

bind csmcg_top csmcg_core_monitor #(.PRESENT(PRESENT)) i_mon (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .power_save_instruction_in, .power_save_idle_in, .irq_pending_in,
  .irq_deliver_out, .cpu_clk_en_out, .periph_clk_en_out, .sleeping_out, .idle_out, .module_clk_en_out,
  .module_reg_wr_ok_out);

// ===== testbench/tb_csmcg_top.sv
`timescale 1ns/1ps
module tb_csmcg_top;
  // The reference clock output module is left absent so presence gating is exercised.
  localparam logic [18:0] PRES = 19'h3_FFFF;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic power_save_instruction_in = 1'b0;
  logic power_save_idle_in = 1'b0;
  logic irq_pending_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic irq_deliver_out, cpu_clk_en_out, periph_clk_en_out, sleeping_out, idle_out;
  logic [18:0] module_clk_en_out, module_reg_wr_ok_out, module_rd_valid_out;
  logic [7:0] gm [19] = '{8'h1B, 8'h1A, 8'h19, 8'h17, 8'h16, 8'h15, 8'h14, 8'h13, 8'h10, 8'h20, 8'h21, 8'h22,
    8'h23, 8'h24, 8'h37, 8'h35, 8'h33, 8'h31, 8'h43};
  logic [15:0] mk [8] = '{16'hF800, 16'h0EF9, 16'h001F, 16'h00AA, 16'h0008, 16'h0000, 16'h0000, 16'h0000};
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  csmcg_top #(.PRESENT(PRES)) i_dut (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .power_save_instruction_in, .power_save_idle_in, .irq_pending_in, .irq_deliver_out,
    .cpu_clk_en_out, .periph_clk_en_out, .sleeping_out, .idle_out, .module_clk_en_out, .module_reg_wr_ok_out,
    .module_rd_valid_out);
  initial begin
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask : rd
  // Counts over a power-of-two span so the result does not depend on the divider phase.
  task automatic cnt(output int c);
    c = 0;
    repeat (256) begin
      @(posedge ref_clk_in);
      #1 if (cpu_clk_en_out === 1'b1) c++;
    end
  endtask : cnt
  ////////////////////////////////////////
  initial begin
    #(50 * 20000);
    mismatches++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 8; a++) rd(4'(a), 16'h0000);
    chk(module_clk_en_out, PRES);
    $display("test reset done");
    for (int a = 0; a < 8; a++) wr(4'(a), 16'hFFFF);
    for (int a = 0; a < 8; a++) rd(4'(a), mk[a]);
    for (int a = 0; a < 5; a++) wr(4'(a), 16'h0000);
    repeat (8) @(posedge ref_clk_in);
    $display("test registers done");
    for (int i = 0; i < 19; i++) begin
      wr(gm[i][7:4], 16'h0001 << gm[i][3:0]);
      repeat (3) @(posedge ref_clk_in);
      #1 chk(module_clk_en_out, PRES & ~(19'h0_0001 << i));
      chk(module_reg_wr_ok_out, PRES & ~(19'h0_0001 << i));
      chk(module_rd_valid_out, PRES & ~(19'h0_0001 << i));
      wr(gm[i][7:4], 16'h0000);
    end
    $display("test gating done");
    for (int r = 0; r < 8; r++) begin
      wr(4'h0, 16'(r << 12) | 16'h0800);
      cnt(n);
      chk(19'(n), 19'(256 >> r));
    end
    wr(4'h0, 16'h7000);
    cnt(n);
    chk(19'(n), 19'h0_0100);
    for (int k = 0; k < 2; k++) begin
      wr(4'h0, k ? 16'hB800 : 16'h3800);
      @(posedge ref_clk_in);
      irq_pending_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      irq_pending_in <= 1'b0;
      rd(4'h0, k ? 16'hB000 : 16'h3800);
      cnt(n);
      chk(19'(n), k ? 19'h0_0100 : 19'h0_0020);
    end
    wr(4'h0, 16'h0000);
    $display("test slow core done");
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_in);
      power_save_instruction_in <= 1'b1;
      power_save_idle_in <= k[0];
      @(posedge ref_clk_in);
      power_save_instruction_in <= 1'b0;
      irq_pending_in <= 1'b1;
      #1 chk({sleeping_out, idle_out, periph_clk_en_out, cpu_clk_en_out, irq_deliver_out}, {~k[0], k[0], k[0], 2'b00});
      chk(module_clk_en_out, k ? PRES : 19'h0_0000);
      n = 0;
      while (irq_deliver_out !== 1'b1 && n < 20) begin
        @(posedge ref_clk_in);
        #1 n++;
      end
      chk(19'(n), 19'h0_0005);
      chk(cpu_clk_en_out, 19'h0_0001);
      @(posedge ref_clk_in);
      irq_pending_in <= 1'b0;
    end
    $display("test power save done");
    close_out();
  end
endmodule : tb_csmcg_top
